/* File: rtl/ssc_top.sv */
// Purpose: Command interpreter of a capacitive slider behind an SPI slave.
// Assumes: SPI clock, select and data are pins, synchronised here; the
//          acquisition engine is outside and reports signal and position.
// Notes:   One burst request pulse per acquisition; the engine answers done.
`include "ssc_cfg.svh"
module ssc_top
    import ssc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       clk_en_i,
    // SPI pins
    input  wire logic       spi_sck_i,
    input  wire logic       spi_ss_n_i,
    input  wire logic       spi_mosi_i,
    output logic            spi_miso_o,
    output logic            host_may_shift_flag_o,
    // Acquisition engine
    input  wire logic [8:0] signal_i,
    input  wire logic [6:0] position_i,
    input  wire logic       polarity_err_i,
    input  wire logic       burst_done_i,
    output logic            burst_req_o,
    output logic            drift_step_o,
    output logic            ref_cal_o,
    output logic            end_cal_o,
    output logic            end_map_en_o,
    output logic [5:0]      prox_thr_o,
    output logic [5:0]      touch_thr_o,
    // Detection pins
    output logic            prox_o,
    output logic            touch_o
);
    // Pin synchronisers: first stage feeds second only
    logic [2:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    logic       sck_d_ff, ss_d_ff, nxt_sck_d, nxt_ss_d;
    // Shift machinery
    logic [7:0] rx_ff, nxt_rx, tx_ff, nxt_tx;
    logic [3:0] bit_cnt_ff, nxt_bit_cnt;
    logic       cmd_ok_ff, nxt_cmd_ok;   // Full byte seen this frame
    // Control state
    ssc_state_e st_ff, nxt_st;
    logic [4:0] burst_left_ff, nxt_burst_left, gap_ff, nxt_gap;  // Gap counts quiet idle cycles
    logic [3:0] drift_cnt_ff, nxt_drift_cnt;
    logic [2:0] free_cnt_ff, nxt_free_cnt;
    logic [5:0] prox_thr_ff, nxt_prox_thr, touch_thr_ff, nxt_touch_thr;
    logic       map_ff, nxt_map, touch_ff, nxt_touch, prox_ff, nxt_prox;
    logic       req_ff, nxt_req, dstep_ff, nxt_dstep;
    logic       rcal_ff, nxt_rcal, ecal_ff, nxt_ecal, miso_ff, nxt_miso;
    logic       pend_end_ff, nxt_pend_end, flag_ff, nxt_flag;
    logic       pend_drift_ff, nxt_pend_drift;
    logic       sck, ss, mosi, sck_rise, sck_fall, ss_rise;
    logic [8:0] touch_lvl, touch_rel;
    logic [7:0] resp;
    ssc_cmd_e   cmd;

    // Opcode decode, shared by select rise handling and the assertions
    function automatic ssc_cmd_e dec_cmd(input logic [7:0] b);
        if (b[7:6] == `SSC_PFX_PROX) begin
            dec_cmd = SSC_CMD_PROX;
        end else if (b[7:6] == `SSC_PFX_TOUCH) begin
            dec_cmd = SSC_CMD_TOUCH;
        end else if (b == `SSC_OP_CAL) begin
            dec_cmd = SSC_CMD_CAL;
        end else if (b == `SSC_OP_ENDCAL) begin
            dec_cmd = SSC_CMD_ENDCAL;
        end else if (b == `SSC_OP_DRIFT) begin
            dec_cmd = SSC_CMD_DRIFT;
        end else begin
            dec_cmd = SSC_CMD_NULL;
        end
    endfunction : dec_cmd

    assign sck  = sync2_ff[0];
    assign ss   = sync2_ff[1];
    assign mosi = sync2_ff[2];
    assign sck_rise = sck & ~sck_d_ff;
    assign sck_fall = ~sck & sck_d_ff;
    assign ss_rise  = ss & ~ss_d_ff;
    assign cmd      = dec_cmd(rx_ff);
    assign touch_lvl = {1'b0, touch_thr_ff, 2'b00};
    // release at or below level minus one eighth
    assign touch_rel = touch_lvl - {3'b000, touch_lvl[8:3]};

    always_comb begin
        if (touch_ff) begin
            resp = {1'b1, position_i};
        end else begin
            resp = {6'h00, polarity_err_i, prox_ff};
        end
    end

    // Next-state computation for all groups
    always_comb begin
        nxt_sync1      = {spi_mosi_i, spi_ss_n_i, spi_sck_i};
        nxt_sync2      = sync1_ff;
        nxt_sck_d      = sck;
        nxt_ss_d       = ss;
        nxt_rx         = rx_ff;
        nxt_tx         = tx_ff;
        nxt_bit_cnt    = bit_cnt_ff;
        nxt_cmd_ok     = cmd_ok_ff;
        nxt_miso       = miso_ff;
        nxt_st         = st_ff;
        nxt_burst_left = burst_left_ff;
        nxt_drift_cnt  = drift_cnt_ff;
        nxt_free_cnt   = free_cnt_ff;
        nxt_prox_thr   = prox_thr_ff;
        nxt_touch_thr  = touch_thr_ff;
        nxt_map        = map_ff;
        nxt_req        = 1'b0;
        nxt_dstep      = 1'b0;
        nxt_rcal       = rcal_ff;
        nxt_ecal       = ecal_ff;
        nxt_gap        = 5'h00;
        nxt_pend_end   = pend_end_ff;
        nxt_pend_drift = pend_drift_ff;
        // proximity compare, no hysteresis; higher is harder
        nxt_prox = ({3'b000, prox_thr_ff} < signal_i);
        if (touch_ff) begin
            nxt_touch = (signal_i > touch_rel);
        end else begin
            nxt_touch = (signal_i > touch_lvl);
        end
        // Frame start loads response, clears counters
        if (!ss && ss_d_ff) begin
            nxt_tx      = resp;
            nxt_miso    = resp[7];
            nxt_bit_cnt = 4'h0;
            nxt_cmd_ok  = 1'b0;
        end
        if (!ss && sck_rise && st_ff == SSC_ST_IDLE) begin
            nxt_rx      = {rx_ff[6:0], mosi};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == 4'h7) begin
                nxt_cmd_ok = 1'b1;
            end
        end
        // shift on falling edge; the first fall drives bit seven
        if (!ss && sck_fall) begin
            nxt_tx   = {tx_ff[6:0], 1'b0};
            nxt_miso = tx_ff[7];
        end
        case (st_ff)
            SSC_ST_IDLE: begin
                if (ss_rise) begin
                    // burst on select rise; null just bursts
                    nxt_req        = 1'b1;
                    nxt_st         = SSC_ST_BURST;
                    nxt_burst_left = 5'h01;
                    nxt_cmd_ok     = 1'b0;
                    if (cmd_ok_ff) begin
                        case (cmd)
                            SSC_CMD_CAL: begin
                                nxt_burst_left = `SSC_CAL_BURSTS;
                                nxt_map        = 1'b0;
                                nxt_rcal       = 1'b1;
                            end
                            SSC_CMD_ENDCAL: begin
                                nxt_burst_left = `SSC_ENDCAL_BURSTS;
                                nxt_pend_end   = 1'b1;
                                nxt_ecal       = 1'b1;
                            end
                            SSC_CMD_DRIFT: begin
                                nxt_pend_drift = ~touch_ff;
                            end
                            SSC_CMD_PROX:  nxt_prox_thr  = rx_ff[5:0];
                            SSC_CMD_TOUCH: nxt_touch_thr = rx_ff[5:0];
                            default: ;
                        endcase
                    end
                end else if (ss && ss_d_ff) begin
                    // free-run after a gap that lets a host start a frame
                    nxt_gap = gap_ff + 5'h01;
                    if (gap_ff == `SSC_FREE_GAP) begin
                        nxt_gap        = 5'h00;
                        nxt_req        = 1'b1;
                        nxt_st         = SSC_ST_BURST;
                        nxt_burst_left = 5'h01;
                        if (free_cnt_ff == `SSC_FREE_DIV - 3'h1) begin
                            nxt_free_cnt   = 3'h0;
                            nxt_pend_drift = ~touch_ff;
                        end else begin
                            nxt_free_cnt = free_cnt_ff + 3'h1;
                        end
                    end
                end
            end
            SSC_ST_BURST: begin
                if (burst_done_i) begin
                    if (pend_drift_ff) begin
                        // one drift step per ten drift requests, from opcodes or free-run
                        nxt_pend_drift = 1'b0;
                        if (drift_cnt_ff == `SSC_DRIFT_DIV - 4'h1) begin
                            nxt_drift_cnt = 4'h0;
                            nxt_dstep     = 1'b1;
                        end else begin
                            nxt_drift_cnt = drift_cnt_ff + 4'h1;
                        end
                    end
                    if (burst_left_ff == 5'h01) begin
                        nxt_st   = SSC_ST_IDLE;
                        nxt_rcal = 1'b0;
                        nxt_ecal = 1'b0;
                        if (pend_end_ff) begin
                            nxt_map      = 1'b1;
                            nxt_pend_end = 1'b0;
                        end
                    end else begin
                        nxt_burst_left = burst_left_ff - 5'h01;
                        nxt_req        = 1'b1;
                    end
                end
            end
            default: nxt_st = SSC_ST_IDLE;
        endcase
        // Host may shift only while idle with nothing requested
        nxt_flag = (nxt_st == SSC_ST_IDLE) & ~nxt_req;
    end

    // Register everything; thresholds survive until reset
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_ff      <= 3'h3;  // Idle pins: clock and select high
            sync2_ff      <= 3'h3;
            sck_d_ff      <= 1'b1;
            ss_d_ff       <= 1'b1;
            rx_ff         <= 8'h00;
            tx_ff         <= 8'h00;
            bit_cnt_ff    <= 4'h0;
            cmd_ok_ff     <= 1'b0;
            miso_ff       <= 1'b0;
            st_ff         <= SSC_ST_IDLE;
            burst_left_ff <= 5'h00;
            drift_cnt_ff  <= 4'h0;
            free_cnt_ff   <= 3'h0;
            prox_thr_ff   <= `SSC_THR_DEFAULT;
            touch_thr_ff  <= `SSC_THR_DEFAULT;
            map_ff        <= 1'b0;
            touch_ff      <= 1'b0;
            prox_ff       <= 1'b0;
            req_ff        <= 1'b0;
            dstep_ff      <= 1'b0;
            rcal_ff       <= 1'b0;
            ecal_ff       <= 1'b0;
            flag_ff       <= 1'b1;
            gap_ff        <= 5'h00;
            pend_end_ff   <= 1'b0;
            pend_drift_ff <= 1'b0;
        end else if (clk_en_i) begin
            sync1_ff      <= nxt_sync1;
            sync2_ff      <= nxt_sync2;
            sck_d_ff      <= nxt_sck_d;
            ss_d_ff       <= nxt_ss_d;
            rx_ff         <= nxt_rx;
            tx_ff         <= nxt_tx;
            bit_cnt_ff    <= nxt_bit_cnt;
            cmd_ok_ff     <= nxt_cmd_ok;
            miso_ff       <= nxt_miso;
            st_ff         <= nxt_st;
            burst_left_ff <= nxt_burst_left;
            drift_cnt_ff  <= nxt_drift_cnt;
            free_cnt_ff   <= nxt_free_cnt;
            prox_thr_ff   <= nxt_prox_thr;
            touch_thr_ff  <= nxt_touch_thr;
            map_ff        <= nxt_map;
            touch_ff      <= nxt_touch;
            prox_ff       <= nxt_prox;
            req_ff        <= nxt_req;
            dstep_ff      <= nxt_dstep;
            rcal_ff       <= nxt_rcal;
            ecal_ff       <= nxt_ecal;
            flag_ff       <= nxt_flag;
            gap_ff        <= nxt_gap;
            pend_end_ff   <= nxt_pend_end;
            pend_drift_ff <= nxt_pend_drift;
        end
    end

    // device starts calibrated; ref_cal marks a recalibration run
    assign spi_miso_o            = miso_ff;
    assign host_may_shift_flag_o = flag_ff;
    assign burst_req_o           = req_ff;
    assign drift_step_o          = dstep_ff;
    assign ref_cal_o             = rcal_ff;
    assign end_cal_o             = ecal_ff;
    assign end_map_en_o          = map_ff;
    assign prox_thr_o            = prox_thr_ff;
    assign touch_thr_o           = touch_thr_ff;
    assign prox_o                = prox_ff;
    assign touch_o               = touch_ff;

    // response byte carries the touch pin level at frame start, and the prox pin only while not touching
    touch_bit_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && !ss && ss_d_ff) |=> tx_ff[`SSC_BIT_TOUCH] == $past(touch_o))
        else $error("touch bit mismatch");
    prox_pin_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && !ss && ss_d_ff && !touch_o) |=> tx_ff[`SSC_BIT_PROX] == $past(prox_o))
        else $error("prox bit missing");
    cal_clear_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && st_ff == SSC_ST_IDLE && ss_rise && cmd_ok_ff && cmd == SSC_CMD_CAL)
        |=> !map_ff) else $error("map not cleared");
    burst_start_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && st_ff == SSC_ST_IDLE && ss_rise) |=> burst_req_o)
        else $error("no burst on select rise");
    prox_thr_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && st_ff == SSC_ST_IDLE && ss_rise && cmd_ok_ff && cmd == SSC_CMD_PROX)
        |=> prox_thr_o == $past(rx_ff[5:0])) else $error("prox load");
    touch_thr_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && st_ff == SSC_ST_IDLE && ss_rise && cmd_ok_ff && cmd == SSC_CMD_TOUCH)
        |=> touch_thr_o == $past(rx_ff[5:0])) else $error("touch load");
    cal_len_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && st_ff == SSC_ST_IDLE && ss_rise && cmd_ok_ff && cmd == SSC_CMD_CAL)
        |=> burst_left_ff == `SSC_CAL_BURSTS) else $error("cal length");
    endcal_len_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && st_ff == SSC_ST_IDLE && ss_rise && cmd_ok_ff && cmd == SSC_CMD_ENDCAL)
        |=> burst_left_ff == `SSC_ENDCAL_BURSTS) else $error("endcal length");
    drift_touch_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && st_ff == SSC_ST_IDLE && ss_rise && cmd_ok_ff && cmd == SSC_CMD_DRIFT
         && touch_ff && !pend_drift_ff) |=> !pend_drift_ff)
        else $error("drift not ignored");
endmodule : ssc_top

/* File: rtl/ssc_cfg.svh */
// Purpose: Constants for the slider SPI command interpreter.
// Assumes: 50 MHz reference clock; SPI mode with falling-edge shift.
// Notes:   All offsets, field positions, defaults and counts live here.
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
`define SSC_OP_NULL      8'h00
`define SSC_OP_CAL       8'h01
`define SSC_OP_ENDCAL    8'h02
`define SSC_OP_DRIFT     8'h03
`define SSC_PFX_PROX     2'h1
`define SSC_PFX_TOUCH    2'h2
`define SSC_THR_DEFAULT  6'h0A
`define SSC_CAL_BURSTS   5'h0A
`define SSC_ENDCAL_BURSTS 5'h14
`define SSC_DRIFT_DIV    4'hA
`define SSC_FREE_DIV     3'h6
`define SSC_FREE_GAP     5'h10   // Quiet idle cycles before a free-run burst
`define SSC_BIT_TOUCH    7
`define SSC_BIT_ERR      1
`define SSC_BIT_PROX     0
`endif

/* File: rtl/ssc_pkg.sv */
// Purpose: Types for the slider SPI command interpreter.
// Assumes: Included constants header.
// Notes:   Command kinds after decoding.
package ssc_pkg;
    typedef enum logic [2:0] {
        SSC_CMD_NULL,
        SSC_CMD_CAL,
        SSC_CMD_ENDCAL,
        SSC_CMD_DRIFT,
        SSC_CMD_PROX,
        SSC_CMD_TOUCH
    } ssc_cmd_e;
    typedef enum logic [1:0] {
        SSC_ST_IDLE,
        SSC_ST_BURST
    } ssc_state_e;
endpackage : ssc_pkg

/* File: bench/ssc_host_model.sv */
// Purpose: Host controller stand-in that drives the slider SPI pins.
// Assumes: Clock idles high; the host shifts on its falling edge.
// Notes:   Four reference clocks per half period, so the link runs at 160 ns.
module ssc_host_model (
    // Reference clock
    input  wire logic       clk_i,
    // SPI pins
    input  wire logic       miso_i,
    output logic            sck_o,
    output logic            ss_n_o,
    output logic            mosi_o,
    // Captured response
    output logic [7:0]      resp_o,
    output logic            resp_vld_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Link clock stands still between frames
    initial begin
        sck_o      = 1'b1;
        ss_n_o     = 1'b1;
        mosi_o     = 1'b0;
        resp_o     = 8'h00;
        resp_vld_o = 1'b0;
    end

    // One frame; fewer than eight bits makes a short or empty frame
    task automatic xfer(input logic [7:0] cmd, input int nbits);
        logic [7:0] sh;
        sh = 8'h00;
        @(posedge clk_i);
        ss_n_o <= 1'b0;
        // Let the device load its response before the first edge
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < nbits; i++) begin
            @(posedge clk_i);
            sck_o  <= 1'b0;
            mosi_o <= cmd[7-i];
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            sh    = {sh[6:0], miso_i};
            repeat (3) @(posedge clk_i);
        end
        repeat (6) @(posedge clk_i);
        ss_n_o     <= 1'b1;
        // Released data line shows the inverse, never a stale value
        mosi_o     <= ~mosi_o;
        resp_o     <= sh;
        resp_vld_o <= 1'b1;
        @(posedge clk_i);
        resp_vld_o <= 1'b0;
    endtask : xfer
endmodule : ssc_host_model

/* File: bench/tb_slider_spi_command_interpreter.sv */
// Purpose: Self-checking bench for the slider command interpreter.
// Assumes: Engine stand-in answers every burst after a fixed count.
// Notes:   Response bytes are checked by a monitor against a queue of notes.
module tb_slider_spi_command_interpreter;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int BURST_LEN = 40;       // Engine cycles per burst
    logic       clk, rst_n, sck, ss_n, mosi, miso, flag, perr, done, req;
    logic       step, rcal, ecal, map_en, prox, touch, resp_vld, cal_seen, en;
    logic [8:0] sig, e_r;
    logic [6:0] pos;
    logic [5:0] pthr, tthr, p, t;
    logic [7:0] resp;
    logic [8:0] exp_q[$];                // Bit 8 set when the byte is known
    logic [7:0] nulls[4] = '{8'h00, 8'h05, 8'hC3, 8'hFF};
    int         bursts, steps, busy_cnt, cycles, n, mismatches, total_checks;

    ssc_top uut (
        .ref_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(en),
        .spi_sck_i(sck), .spi_ss_n_i(ss_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .host_may_shift_flag_o(flag), .signal_i(sig), .position_i(pos),
        .polarity_err_i(perr), .burst_done_i(done), .burst_req_o(req),
        .drift_step_o(step), .ref_cal_o(rcal), .end_cal_o(ecal),
        .end_map_en_o(map_en), .prox_thr_o(pthr), .touch_thr_o(tthr),
        .prox_o(prox), .touch_o(touch));

    ssc_host_model u_host (
        .clk_i(clk), .miso_i(miso), .sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi),
        .resp_o(resp), .resp_vld_o(resp_vld));

    // Reference clock, 20 ns
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Engine stand-in: each request ends after a fixed burst length
    always @(posedge clk) begin
        done <= 1'b0;
        if (req === 1'b1) begin
            busy_cnt <= BURST_LEN;
            bursts   <= bursts + 1;
        end else if (busy_cnt == 1) begin
            busy_cnt <= 0;
            done     <= 1'b1;
        end else if (busy_cnt != 0) begin
            busy_cnt <= busy_cnt - 1;
        end
        if (step === 1'b1) steps <= steps + 1;
        if (rcal === 1'b1) cal_seen <= 1'b1;
    end

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // Response monitor: oldest note against each captured byte
    always @(posedge clk) begin
        if (resp_vld === 1'b1) begin
            e_r = exp_q.pop_front();
            if (e_r[8]) check("resp", resp, e_r[7:0]);
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            summarize();
        end
    end

    // Hosts must not shift while the device is busy
    task automatic wait_idle;
        n = 0;
        while (flag !== 1'b1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_idle

    task automatic frame(input logic [7:0] op, input int nb, input int eb, input logic [8:0] er);
        wait_idle();
        exp_q.push_back(er);
        u_host.xfer(op, nb);
        bursts <= 0;
        repeat (8) @(posedge clk);
        wait_idle();
        // Let the engine stand-in count the last pulses first
        @(posedge clk);
        check("bursts", 8'(bursts), 8'(eb));
    endtask : frame

    task automatic defaults(input string nm);
        check("prox_thr", {2'h0, pthr}, 8'h0A);
        check("touch_thr", {2'h0, tthr}, 8'h0A);
        check("end_map", {7'h00, map_en}, 8'h00);
        $display("test %s done", nm);
    endtask : defaults

    // Burst at a signal level, then read the pins and the next response
    task automatic detect(input logic [8:0] s, input logic ep, input logic et,
                          input logic [7:0] er);
        sig <= s;
        frame(8'h00, 8, 1, 9'h000);
        check("prox_o", {7'h00, prox}, {7'h00, ep});
        check("touch_o", {7'h00, touch}, {7'h00, et});
        frame(8'h00, 8, 1, {1'b1, er});
    endtask : detect

    initial begin
        rst_n = 1'b0;
        en = 1'b1;
        sig = 9'h000;
        pos = 7'h2A;
        perr = 1'b0;
        done = 1'b0;
        {bursts, steps, busy_cnt, cycles, cal_seen} = '0;
        void'($urandom(2965));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        defaults("reset");
        foreach (nulls[i]) frame(nulls[i], 8, 1, 9'h000);
        frame(8'h01, 4, 1, 9'h000);
        frame(8'h00, 0, 1, 9'h000);
        defaults("null");
        // start order: calibrate, end calibrate, thresholds
        frame(8'h01, 8, 10, 9'h000);
        check("ref_cal", {7'h00, cal_seen}, 8'h01);
        frame(8'h02, 8, 20, 9'h000);
        check("end_map", {7'h00, map_en}, 8'h01);
        frame(8'h01, 8, 10, 9'h000);
        check("end_map", {7'h00, map_en}, 8'h00);
        t = 6'(1 + $urandom % 63);
        frame({2'b10, t}, 8, 1, 9'h000);
        check("touch_thr", {2'h0, tthr}, {2'h0, t});
        p = 6'(1 + $urandom % 50);
        frame({2'b01, p}, 8, 1, 9'h000);
        check("prox_thr", {2'h0, pthr}, {2'h0, p});
        frame(8'h90, 8, 1, 9'h000);
        $display("test thresholds done");
        detect({3'h0, p}, 1'b0, 1'b0, 8'h00);
        detect({3'h0, p} + 9'h001, 1'b1, 1'b0, 8'h01);
        perr <= 1'b1;
        detect({3'h0, p} + 9'h001, 1'b1, 1'b0, 8'h03);
        frame(8'h01, 8, 10, 9'h103);
        perr <= 1'b0;
        detect(9'd65, 1'b1, 1'b1, 8'hAA);
        detect(9'd60, 1'b1, 1'b1, 8'hAA);
        detect(9'd56, 1'b1, 1'b0, 8'h01);
        $display("test detection done");
        // drift opcodes stand in for nulls
        steps <= 0;
        repeat (10) frame(8'h03, 8, 1, 9'h000);
        check("drift", 8'(steps), 8'h01);
        detect(9'd100, 1'b1, 1'b1, 8'hAA);
        steps <= 0;
        repeat (10) frame(8'h03, 8, 1, 9'h000);
        check("drift_touch", 8'(steps), 8'h00);
        sig <= 9'h000;
        frame(8'h00, 8, 1, 9'h000);
        // select held high keeps bursts going
        steps <= 0;
        bursts <= 0;
        n = 0;
        while (bursts < 70 && n < 8000) begin
            @(posedge clk);
            n++;
        end
        check("free_drift", 8'(steps), 8'h01);
        $display("test drift done");
        // Clock enable low freezes the pins against a large signal
        en  <= 1'b0;
        sig <= 9'd100;
        repeat (4) @(posedge clk);
        check("frozen", {6'h00, prox, touch}, 8'h00);
        en  <= 1'b1;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        defaults("second reset");
        summarize();
    end
endmodule : tb_slider_spi_command_interpreter
